// file: hdl/nfc_pkg.sv
// Overview of operation
// - read drives address, select and gate low
// - no autoselect while programming or erasing
// - reset command leaves autoselect
// - protection check uses sector address bits
// - write: select and strobe low, gate high
// - hardware reset aborts; reissue the sequence
// - single word program is four writes
// - status bits polled during programming
package nfc_pkg;
    localparam int ADDR_W = 23;
    localparam int DATA_W = 16;
    localparam int PAGE_BITS = 3;
    // timing in ns, cycle counts rounded up at 100 MHz
    localparam int CLK_NS = 10;
    localparam int ACC_NS = 70;
    localparam int OE_NS = 25;
    localparam int PACC_NS = 25;
    localparam int WP_NS = 40;
    localparam int WH_NS = 30;
    localparam int ACC_CYC = (ACC_NS + CLK_NS - 1) / CLK_NS;
    localparam int OE_CYC = (OE_NS + CLK_NS - 1) / CLK_NS;
    localparam int PACC_CYC = (PACC_NS + CLK_NS - 1) / CLK_NS;
    localparam int WP_CYC = (WP_NS + CLK_NS - 1) / CLK_NS;
    localparam int WH_CYC = (WH_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W = 8;
    // command cycles: addresses and data of the unlock and command writes
    localparam logic [ADDR_W-1:0] UNLOCK_A1 = 23'h00_0555;
    localparam logic [ADDR_W-1:0] UNLOCK_A2 = 23'h00_02AA;
    localparam logic [DATA_W-1:0] UNLOCK_D1 = 16'h00AA;
    localparam logic [DATA_W-1:0] UNLOCK_D2 = 16'h0055;
    localparam logic [DATA_W-1:0] CMD_PROG = 16'h00A0;
    localparam logic [DATA_W-1:0] CMD_AUTOSEL = 16'h0090;
    localparam logic [DATA_W-1:0] CMD_RESET = 16'h00F0;
    localparam logic [7:0] DQ7_BIT = 8'h07;
    localparam logic [7:0] DQ6_BIT = 8'h06;
    localparam logic [7:0] DQ5_BIT = 8'h05;
    localparam logic [7:0] BYTE_MASK = 8'hFF;
    typedef enum logic [2:0] {
        NFC_OP_READ,
        NFC_OP_PROG,
        NFC_OP_AUTOSEL,
        NFC_OP_RESET,
        NFC_OP_RAW
    } nfc_op_e;
endpackage : nfc_pkg

// file: hdl/nfc_cycle.sv
`timescale 1ns/10ps
`default_nettype none
// one bus cycle on the flash pins; caller holds addr/data until done
module nfc_cycle
    import nfc_pkg::*;
#(
    parameter int ACC = ACC_CYC,
    parameter int PACC = PACC_CYC,
    parameter int OE = OE_CYC,
    parameter int WP = WP_CYC,
    parameter int WH = WH_CYC
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic start,
    input wire logic isWrite,
    input wire logic keepSelect,
    input wire logic samePage,
    input wire logic [DATA_W-1:0] wrData,
    input wire logic [DATA_W-1:0] dqIn,
    output logic selectN,
    output logic gateN,
    output logic strobeN,
    output logic [DATA_W-1:0] dqOut,
    output logic dqOe,
    output logic [DATA_W-1:0] rdData,
    output logic done
);
    typedef enum logic [1:0] {NFC_C_IDLE, NFC_C_RD, NFC_C_WR, NFC_C_HOLD} nfc_cyc_e;
    nfc_cyc_e state_q;
    logic [CNT_W-1:0] cnt_q;
    logic pageOpen_q;

    function automatic logic [CNT_W-1:0] cyc(input int n);
        return CNT_W'((n < 1) ? 1 : n);
    endfunction : cyc

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_q <= NFC_C_IDLE;
            cnt_q <= '0;
            selectN <= 1'b1;
            gateN <= 1'b1;
            strobeN <= 1'b1;
            dqOe <= 1'b0;
            dqOut <= '0;
            rdData <= '0;
            done <= 1'b0;
            pageOpen_q <= 1'b0;
        end else begin
            done <= 1'b0;
            unique case (state_q)
                NFC_C_IDLE: begin
                    if (start) begin
                        selectN <= 1'b0;
                        if (isWrite) begin
                            // gate high, strobe low; address taken at later fall
                            gateN <= 1'b1;
                            strobeN <= 1'b0;
                            dqOe <= 1'b1;
                            dqOut <= wrData;
                            cnt_q <= cyc(WP);
                            state_q <= NFC_C_WR;
                        end else begin
                            // strobe held high during reads
                            strobeN <= 1'b1;
                            gateN <= 1'b0;
                            dqOe <= 1'b0;
                            // short wait only inside an open page
                            cnt_q <= (samePage && pageOpen_q && !selectN) ? cyc(PACC)
                                     : cyc((ACC > OE) ? ACC : OE);
                            state_q <= NFC_C_RD;
                        end
                    end else if (!keepSelect) begin
                        selectN <= 1'b1; // releasing select forces a full access next
                        gateN <= 1'b1;
                        pageOpen_q <= 1'b0;
                    end
                end
                NFC_C_RD: begin
                    if (cnt_q == cyc(1)) begin
                        rdData <= dqIn;
                        done <= 1'b1;
                        pageOpen_q <= 1'b1;
                        // gate edge on every status read, else the toggle bit cannot move
                        gateN <= 1'b1;
                        state_q <= NFC_C_IDLE;
                    end else begin
                        cnt_q <= cnt_q - cyc(1);
                    end
                end
                NFC_C_WR: begin
                    if (cnt_q == cyc(1)) begin
                        selectN <= 1'b1; // data taken on first rising edge
                        strobeN <= 1'b1;
                        pageOpen_q <= 1'b0;
                        cnt_q <= cyc(WH);
                        state_q <= NFC_C_HOLD;
                    end else begin
                        cnt_q <= cnt_q - cyc(1);
                    end
                end
                NFC_C_HOLD: begin
                    if (cnt_q == cyc(1)) begin
                        dqOe <= 1'b0;
                        done <= 1'b1;
                        state_q <= NFC_C_IDLE;
                    end else begin
                        cnt_q <= cnt_q - cyc(1);
                    end
                end
            endcase
        end
    end
endmodule : nfc_cycle
`default_nettype wire

// file: hdl/nfc_host.sv
`timescale 1ns/10ps
`default_nettype none
module nfc_host
    import nfc_pkg::*;
#(
    parameter int POLL_LIMIT = 100000
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic reqValid,
    input wire nfc_pkg::nfc_op_e reqOp,
    input wire logic reqWrite,
    input wire logic [nfc_pkg::ADDR_W-1:0] reqAddr,
    input wire logic [nfc_pkg::DATA_W-1:0] reqData,
    input wire logic byteMode,
    input wire logic accelMode,
    output logic reqReady,
    output logic rspValid,
    output logic [nfc_pkg::DATA_W-1:0] rspData,
    output logic rspError,
    output logic [nfc_pkg::ADDR_W-1:0] addressLines,
    output logic deviceSelectN,
    output logic outputGateN,
    output logic writeStrobeN,
    output logic hwResetN,
    output logic widthSelectN,
    output logic [nfc_pkg::DATA_W-1:0] dataLinesOut,
    output logic dataLinesOe,
    input wire logic [nfc_pkg::DATA_W-1:0] dataLinesIn
);
    import nfc_pkg::*;

    // -----------------------------------------------------------------
    // sequencer
    // -----------------------------------------------------------------
    typedef enum logic [2:0] {
        NFC_S_IDLE, NFC_S_ISSUE, NFC_S_WAIT, NFC_S_POLL, NFC_S_REPLY
    } nfc_state_e;
    nfc_state_e state_q;
    nfc_op_e op_q;
    logic [ADDR_W-1:0] addr_q;
    logic [DATA_W-1:0] data_q;
    logic [2:0] step_q;
    logic [2:0] last_q;
    logic [31:0] poll_q;
    logic [DATA_W-1:0] prevStat_q;
    logic pollFirst_q;
    logic cycStart_q;
    logic cycGo_q;
    logic cycWrite_q;
    logic [ADDR_W-1:0] cycAddr_q;
    logic [DATA_W-1:0] cycData_q;
    logic cycDone;
    logic [DATA_W-1:0] cycRd;
    logic [ADDR_W-1:0] prevRdAddr_q;
    logic samePage;
    logic keepSel;

    // page bits above the word index
    function automatic logic pageMatch(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] b);
        return a[ADDR_W-1:PAGE_BITS] == b[ADDR_W-1:PAGE_BITS];
    endfunction : pageMatch

    function automatic logic bitOf(input logic [DATA_W-1:0] v, input logic [7:0] i);
        return v[i[3:0]];
    endfunction : bitOf

    assign samePage = pageMatch(cycAddr_q, prevRdAddr_q);
    assign keepSel = (state_q == NFC_S_POLL);

    // step count per operation; accel mode skips unlocks of programs only
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_q <= NFC_S_IDLE;
            op_q <= NFC_OP_READ;
            addr_q <= '0;
            data_q <= '0;
            step_q <= '0;
            last_q <= '0;
            reqReady <= 1'b0;
            rspValid <= 1'b0;
            rspData <= '0;
            rspError <= 1'b0;
            cycStart_q <= 1'b0;
            cycWrite_q <= 1'b0;
            cycAddr_q <= '0;
            cycData_q <= '0;
            poll_q <= '0;
            prevStat_q <= '0;
            pollFirst_q <= 1'b0;
            prevRdAddr_q <= '0;
        end else begin
            cycStart_q <= 1'b0;
            rspValid <= 1'b0;
            unique case (state_q)
                NFC_S_IDLE: begin
                    reqReady <= 1'b1;
                    if (reqValid && reqReady) begin
                        reqReady <= 1'b0;
                        op_q <= reqOp;
                        addr_q <= reqAddr;
                        data_q <= reqData;
                        rspError <= 1'b0;
                        unique case (reqOp)
                            NFC_OP_PROG: begin
                                step_q <= accelMode ? 3'd2 : 3'd0;
                                last_q <= 3'd3;
                            end
                            NFC_OP_AUTOSEL: begin
                                step_q <= 3'd0;
                                last_q <= 3'd3;
                            end
                            NFC_OP_RESET: begin
                                step_q <= 3'd2;
                                last_q <= 3'd2;
                            end
                            default: begin
                                step_q <= 3'd3;
                                last_q <= 3'd3;
                            end
                        endcase
                        state_q <= NFC_S_ISSUE;
                    end
                end
                NFC_S_ISSUE: begin
                    cycStart_q <= 1'b1;
                    cycWrite_q <= 1'b1;
                    unique case (step_q)
                        3'd0: begin
                            cycAddr_q <= UNLOCK_A1;
                            cycData_q <= UNLOCK_D1;
                        end
                        3'd1: begin
                            cycAddr_q <= UNLOCK_A2;
                            cycData_q <= UNLOCK_D2;
                        end
                        3'd2: begin
                            cycAddr_q <= (op_q == NFC_OP_RESET) ? addr_q : UNLOCK_A1;
                            cycData_q <= (op_q == NFC_OP_PROG) ? CMD_PROG
                                       : (op_q == NFC_OP_AUTOSEL) ? CMD_AUTOSEL : CMD_RESET;
                        end
                        default: begin
                            cycAddr_q <= addr_q;
                            cycData_q <= data_q;
                            // reads and identifier reads take the read path
                            cycWrite_q <= (op_q == NFC_OP_PROG) ||
                                          (op_q == NFC_OP_RAW && reqWrite);
                        end
                    endcase
                    state_q <= NFC_S_WAIT;
                end
                NFC_S_WAIT: begin
                    if (cycDone) begin
                        if (!cycWrite_q) begin
                            prevRdAddr_q <= cycAddr_q;
                            // byte mode keeps only the low byte
                            rspData <= byteMode ? (cycRd & DATA_W'(BYTE_MASK)) : cycRd;
                        end
                        if (step_q != last_q) begin
                            step_q <= step_q + 3'd1;
                            state_q <= NFC_S_ISSUE;
                        end else if (op_q == NFC_OP_PROG) begin
                            // no commands until status shows completion
                            cycStart_q <= 1'b1;
                            cycWrite_q <= 1'b0;
                            pollFirst_q <= 1'b1;
                            poll_q <= '0;
                            state_q <= NFC_S_POLL;
                        end else begin
                            state_q <= NFC_S_REPLY;
                        end
                    end
                end
                NFC_S_POLL: begin
                    if (cycDone) begin
                        prevStat_q <= cycRd;
                        prevRdAddr_q <= cycAddr_q;
                        pollFirst_q <= 1'b0;
                        poll_q <= poll_q + 32'd1;
                        // toggle bit stops when done; true data on DQ7
                        if (!pollFirst_q && bitOf(cycRd, DQ6_BIT) == bitOf(prevStat_q, DQ6_BIT)
                            && bitOf(cycRd, DQ7_BIT) == bitOf(data_q, DQ7_BIT)) begin
                            // bits only clear; 1 written over 0 reads back 0
                            rspError <= ((data_q & ~cycRd) != '0) && !byteMode;
                            rspData <= cycRd;
                            state_q <= NFC_S_REPLY;
                        end else if (bitOf(cycRd, DQ5_BIT) || poll_q >= 32'(POLL_LIMIT)) begin
                            // failure: send reset so the device is back in read
                            rspError <= 1'b1;
                            rspData <= cycRd;
                            op_q <= NFC_OP_RESET;
                            step_q <= 3'd2;
                            last_q <= 3'd2;
                            state_q <= NFC_S_ISSUE;
                        end else begin
                            cycStart_q <= 1'b1;
                        end
                    end
                end
                NFC_S_REPLY: begin
                    rspValid <= 1'b1; // any address order allowed
                    state_q <= NFC_S_IDLE;
                end
                default: state_q <= NFC_S_IDLE;
            endcase
        end
    end

    // -----------------------------------------------------------------
    // pins
    // -----------------------------------------------------------------
    // reset pulled low only under rst, aborting device work
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            hwResetN <= 1'b0;
            widthSelectN <= 1'b1;
            addressLines <= '0;
            cycGo_q <= 1'b0;
        end else begin
            hwResetN <= 1'b1;
            // cycle starts one clock after the address moves, giving address setup
            cycGo_q <= cycStart_q;
            widthSelectN <= !byteMode;
            if (cycStart_q) begin
                addressLines <= cycAddr_q; // stable before select falls
            end
        end
    end

    nfc_cycle u_cycle (
        .clk_sys(clk_sys),
        .rst(rst),
        .start(cycGo_q),
        .isWrite(cycWrite_q),
        .keepSelect(keepSel),
        .samePage(samePage),
        .wrData(cycData_q),
        .dqIn(dataLinesIn),
        .selectN(deviceSelectN),
        .gateN(outputGateN),
        .strobeN(writeStrobeN),
        .dqOut(dataLinesOut),
        .dqOe(dataLinesOe),
        .rdData(cycRd),
        .done(cycDone)
    );
endmodule : nfc_host
`default_nettype wire

// file: verification/nfc_host_properties.sv
`timescale 1ns/10ps
`default_nettype none
module nfc_props (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic reqValid,
    input wire logic reqReady,
    input wire logic rspValid,
    input wire logic byteMode,
    input wire logic [nfc_pkg::ADDR_W-1:0] addressLines,
    input wire logic deviceSelectN,
    input wire logic outputGateN,
    input wire logic writeStrobeN,
    input wire logic widthSelectN,
    input wire logic [nfc_pkg::DATA_W-1:0] dataLinesOut,
    input wire logic dataLinesOe
);
    import nfc_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // ----
    // bus cycle, width select and request/response handshake checks
    // ----
    sequence strobeLow4;
        !writeStrobeN [*4];
    endsequence
    sequence strobeHeld;
        !writeStrobeN ##1 !writeStrobeN;
    endsequence
    AST_READ_CYCLE: assert property (
        !outputGateN |-> writeStrobeN && !deviceSelectN && !dataLinesOe)
        else $error("gate low outside a read cycle");
    AST_WRITE_CYCLE: assert property (
        !writeStrobeN |-> outputGateN && !deviceSelectN && dataLinesOe)
        else $error("strobe low outside a write cycle");
    AST_WRITE_PULSE: assert property (
        $fell(writeStrobeN) |-> strobeLow4 ##1 writeStrobeN)
        else $error("write strobe width wrong");
    AST_WRITE_HOLD: assert property (
        strobeHeld |-> $stable(addressLines) && $stable(dataLinesOut))
        else $error("address or data moved under strobe");
    AST_DATA_AFTER_STROBE: assert property (
        $rose(writeStrobeN) |-> (dataLinesOe && $stable(dataLinesOut)) [*2])
        else $error("data released too early");
    AST_WIDTH_FOLLOWS: assert property (
        $changed(byteMode) |-> ##[1:2] (widthSelectN == !byteMode))
        else $error("width select does not follow byte mode");
    AST_ONE_OUTSTANDING: assert property (
        reqValid && reqReady |=> !reqReady)
        else $error("ready stayed high after a request");
    AST_RSP_PULSE: assert property (
        rspValid |=> !rspValid)
        else $error("response longer than one cycle");
endmodule : nfc_props
bind nfc_host nfc_props u_props (.clk_sys(clk_sys), .rst(rst), .reqValid(reqValid),
    .reqReady(reqReady), .rspValid(rspValid), .byteMode(byteMode),
    .addressLines(addressLines), .deviceSelectN(deviceSelectN), .outputGateN(outputGateN),
    .writeStrobeN(writeStrobeN), .widthSelectN(widthSelectN), .dataLinesOut(dataLinesOut),
    .dataLinesOe(dataLinesOe));
`default_nettype wire

// file: verification/nfc_flash_model.sv
`timescale 1ns/10ps
`default_nettype none
module nfc_flash_model #(
    parameter int PROG_NS = 500,
    parameter int ACCESS_NS = 20,
    // arbitrary identifier value
    parameter logic [15:0] MAKER_ID = 16'h005A
) (
    input wire logic [nfc_pkg::ADDR_W-1:0] addressLines,
    input wire logic deviceSelectN,
    input wire logic outputGateN,
    input wire logic writeStrobeN,
    input wire logic hwResetN,
    input wire logic widthSelectN,
    input wire logic accelHigh,
    input wire logic [nfc_pkg::DATA_W-1:0] dataLines,
    output logic [nfc_pkg::DATA_W-1:0] dataDrive
);
    import nfc_pkg::*;
    logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
    logic [ADDR_W-1:0] rdAddr, wrAddr, progAddr;
    logic [DATA_W-1:0] progData, rdVal, drvVal;
    logic [DATA_W-1:0] lastVal = 16'h0000;
    logic busy = 1'b0;
    logic autoSel = 1'b0;
    logic toggle = 1'b0;
    int step = 0;
    // ----
    // command tracking and array
    // ----
    function automatic logic [DATA_W-1:0] word(input logic [ADDR_W-1:0] a);
        return mem.exists(a) ? mem[a] : 16'hFFFF;
    endfunction : word
    task automatic command(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        if (busy)
            return;
        if (d[7:0] == 8'hF0) begin
            autoSel = 1'b0;
            step = 0;
        end else if (step == 3) begin
            progAddr = a;
            progData = widthSelectN ? d : {8'hFF, d[7:0]};
            busy = 1'b1;
            step = 0;
        end else if (step == 0 && accelHigh && d[7:0] == 8'hA0)
            step = 3;
        else if (step == 0 && a[10:0] == 11'h555 && d[7:0] == 8'hAA)
            step = 1;
        else if (step == 1 && a[10:0] == 11'h2AA && d[7:0] == 8'h55)
            step = 2;
        else if (step == 2 && d[7:0] == 8'hA0)
            step = 3;
        else if (step == 2 && d[7:0] == 8'h90) begin
            autoSel = 1'b1;
            step = 0;
        end else
            step = 0;
    endtask : command
    always @(negedge deviceSelectN) rdAddr = addressLines;
    // page reads move the low bits while selected
    always @(addressLines) if (!deviceSelectN) rdAddr = addressLines;
    always @(negedge outputGateN) if (busy) toggle = ~toggle;
    always @(negedge writeStrobeN) wrAddr = addressLines;
    always @(posedge writeStrobeN) if (hwResetN) command(wrAddr, dataLines);
    always @(negedge hwResetN) begin
        busy = 1'b0;
        autoSel = 1'b0;
        step = 0;
    end
    always @(posedge busy) begin
        #(PROG_NS);
        if (busy) begin
            mem[progAddr] = word(progAddr) & progData;
            busy = 1'b0;
        end
    end
    always @* begin
        if (busy)
            rdVal = {8'h00, ~progData[7], toggle, 6'h00};
        else if (autoSel)
            rdVal = {8'h00, rdAddr[7:0] == 8'h00 ? MAKER_ID[7:0] : 8'h00};
        else
            rdVal = word(rdAddr);
        // released lines show no stale value
        drvVal = ~lastVal;
        if (!deviceSelectN && !outputGateN && hwResetN) begin
            drvVal[7:0] = rdVal[7:0];
            if (widthSelectN)
                drvVal[15:8] = rdVal[15:8];
        end
    end
    always @(posedge deviceSelectN or posedge outputGateN) lastVal = dataDrive;
    assign #(ACCESS_NS) dataDrive = drvVal;
endmodule : nfc_flash_model
`default_nettype wire

// file: verification/flash_read_program_interface_test.sv
`timescale 1ns/10ps
`default_nettype none
module flash_read_program_interface_test;
    import nfc_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic reqValid = 1'b0;
    logic reqWrite = 1'b0;
    logic byteMode = 1'b0;
    logic accelMode = 1'b0;
    nfc_op_e reqOp = NFC_OP_READ;
    logic [ADDR_W-1:0] reqAddr = '0;
    logic [ADDR_W-1:0] addressLines;
    logic [DATA_W-1:0] reqData = '0;
    logic [DATA_W-1:0] rspData, dataLinesOut, modelDrive, busLevel, got;
    logic reqReady, rspValid, rspError, deviceSelectN, outputGateN, writeStrobeN;
    logic hwResetN, widthSelectN, dataLinesOe, gotErr;
    int errCount = 0;
    int totalChecks = 0;
    assign busLevel = dataLinesOe ? dataLinesOut : modelDrive;
    nfc_host #(.POLL_LIMIT(50)) DUT (.clk_sys(clk_sys), .rst(rst), .reqValid(reqValid),
        .reqOp(reqOp), .reqWrite(reqWrite), .reqAddr(reqAddr), .reqData(reqData),
        .byteMode(byteMode), .accelMode(accelMode), .reqReady(reqReady), .rspValid(rspValid),
        .rspData(rspData), .rspError(rspError), .addressLines(addressLines),
        .deviceSelectN(deviceSelectN), .outputGateN(outputGateN), .writeStrobeN(writeStrobeN),
        .hwResetN(hwResetN), .widthSelectN(widthSelectN), .dataLinesOut(dataLinesOut),
        .dataLinesOe(dataLinesOe), .dataLinesIn(busLevel));
    nfc_flash_model u_flash (.addressLines(addressLines), .deviceSelectN(deviceSelectN),
        .outputGateN(outputGateN), .writeStrobeN(writeStrobeN), .hwResetN(hwResetN),
        .widthSelectN(widthSelectN), .accelHigh(accelMode), .dataLines(busLevel),
        .dataDrive(modelDrive));
    initial forever #5 clk_sys = ~clk_sys;
    // ----
    // shared tasks
    // ----
    task automatic endOfTest;
        if (errCount == 0 && totalChecks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : endOfTest
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
        totalChecks++;
        if (seen !== exp) begin
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
            errCount++;
        end
    endtask : check
    task automatic request(input nfc_op_e op, input logic [22:0] a, input logic [15:0] d);
        int n;
        n = 0;
        @(negedge clk_sys);
        while (reqReady !== 1'b1 && n < 300) begin
            @(negedge clk_sys);
            n++;
        end
        if (reqReady !== 1'b1) begin
            $display("MISMATCH request ready expected 1 seen timeout");
            errCount++;
            endOfTest();
        end
        reqOp = op;
        reqAddr = a;
        reqData = d;
        reqValid = 1'b1;
        @(negedge clk_sys);
        reqValid = 1'b0;
        n = 0;
        while (rspValid !== 1'b1 && n < 3000) begin
            @(negedge clk_sys);
            n++;
        end
        got = rspData;
        gotErr = rspError;
        if (rspValid !== 1'b1) begin
            $display("MISMATCH response wait expected 1 seen timeout");
            errCount++;
            endOfTest();
        end
    endtask : request
    // ----
    // scenarios
    // ----
    task automatic scProgram;
        request(NFC_OP_READ, 23'h00_0123, 16'h0000);
        check("erased word", 16'hFFFF, got);
        request(NFC_OP_PROG, 23'h00_0123, 16'h12C4);
        check("program error", 16'h0000, {15'h0000, gotErr});
        request(NFC_OP_READ, 23'h00_0123, 16'h0000);
        check("programmed word", 16'h12C4, got);
        request(NFC_OP_PROG, 23'h00_0123, 16'h1084);
        request(NFC_OP_READ, 23'h00_0123, 16'h0000);
        check("reprogrammed word", 16'h1084, got);
        request(NFC_OP_PROG, 23'h00_0123, 16'h34FF);
        check("set bit flagged", 16'h0001, {15'h0000, gotErr});
        request(NFC_OP_PROG, 23'h7F_0000, 16'h00AA);
        request(NFC_OP_READ, 23'h7F_0000, 16'h0000);
        check("far sector word", 16'h00AA, got);
    endtask : scProgram
    task automatic scAccelByte;
        accelMode = 1'b1;
        request(NFC_OP_PROG, 23'h00_0456, 16'h5A5A);
        accelMode = 1'b0;
        request(NFC_OP_READ, 23'h00_0456, 16'h0000);
        check("accelerated word", 16'h5A5A, got);
        byteMode = 1'b1;
        request(NFC_OP_READ, 23'h00_0456, 16'h0000);
        check("byte lane", 16'h005A, got);
        byteMode = 1'b0;
    endtask : scAccelByte
    task automatic scAutoselect;
        request(NFC_OP_AUTOSEL, 23'h00_0000, 16'h0000);
        check("maker code", {8'h00, u_flash.MAKER_ID[7:0]}, got);
        request(NFC_OP_AUTOSEL, 23'h7E_0002, 16'h0000);
        check("protect code", 16'h0000, got);
        request(NFC_OP_RESET, 23'h00_0000, 16'h0000);
        request(NFC_OP_READ, 23'h00_0123, 16'h0000);
        check("array after exit", 16'h1084, got);
    endtask : scAutoselect
    task automatic scBadSequence;
        reqWrite = 1'b1;
        request(NFC_OP_RAW, 23'h00_0555, 16'h00AA);
        request(NFC_OP_RAW, 23'h00_0123, 16'h0077);
        request(NFC_OP_RAW, 23'h00_0555, 16'h00A0);
        request(NFC_OP_RAW, 23'h00_0456, 16'h0000);
        reqWrite = 1'b0;
        request(NFC_OP_RAW, 23'h00_0456, 16'h0000);
        check("array after bad sequence", 16'h5A5A, got);
    endtask : scBadSequence
    task automatic scResetAbort;
        @(negedge clk_sys);
        reqOp = NFC_OP_PROG;
        reqAddr = 23'h00_0789;
        reqData = 16'h0F0F;
        reqValid = 1'b1;
        @(negedge clk_sys);
        reqValid = 1'b0;
        repeat (45) @(negedge clk_sys);
        rst = 1'b1;
        repeat (3) @(negedge clk_sys);
        check("reset pin", 16'h0000, {15'h0000, hwResetN});
        rst = 1'b0;
        request(NFC_OP_READ, 23'h00_0789, 16'h0000);
        check("aborted word", 16'hFFFF, got);
        request(NFC_OP_PROG, 23'h00_0789, 16'h0F0F);
        request(NFC_OP_READ, 23'h00_0789, 16'h0000);
        check("reissued word", 16'h0F0F, got);
    endtask : scResetAbort
    initial begin
        repeat (3) @(negedge clk_sys);
        rst = 1'b0;
        scProgram();
        scAccelByte();
        scAutoselect();
        scBadSequence();
        scResetAbort();
        endOfTest();
    end
endmodule : flash_read_program_interface_test
`default_nettype wire
